// *** dv/rta_bcc_sink.sv ***
// Far-end model: back control channel taking forwarded transactions
`timescale 1ns/1ps
module rta_bcc_sink (
  input  wire logic       i_clk,
  input  wire logic       i_fwd_valid,
  input  wire logic [6:0] i_fwd_addr,
  input  wire logic       i_fwd_port
);
  logic [7:0] got_q[$];
  // One pulse is one transaction towards the serializer
  always @(posedge i_clk)
    if (i_fwd_valid === 1'b1)
      got_q.push_back({i_fwd_addr, i_fwd_port});
endmodule

// *** dv/rta_remap_tb.sv ***
// Self-checking bench of the remote target address remap block
`timescale 1ns/1ps
module rta_remap_tb;
  import rta_pkg::*;
  logic        i_clk = 0, i_rst = 1, i_port_sel = 0, i_reg_wr = 0, i_reg_rd = 0;
  logic [7:0]  i_reg_addr = 0, i_reg_wdata = 0, o_reg_rdata;
  logic        o_reg_hit, i_xlat_req = 0, i_xlat_port = 0, o_fwd_valid, o_fwd_port;
  logic [2:0]  i_xlat_slot = 0;
  logic [6:0]  i_xlat_alias = 0, o_fwd_addr;
  logic [6:0]  mdl[2][5];
  logic [31:0] seed = 32'h009fb655;
  logic [7:0]  lastf = 8'h00;
  int          fails = 0, tests_run = 0, nfwd = 0;

  always #5 i_clk = ~i_clk;

  rta_remap u_dut (.i_clk(i_clk), .i_rst(i_rst), .i_port_sel(i_port_sel),
    .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .o_reg_hit(o_reg_hit),
    .i_xlat_req(i_xlat_req), .i_xlat_port(i_xlat_port), .i_xlat_slot(i_xlat_slot),
    .i_xlat_alias(i_xlat_alias), .o_fwd_valid(o_fwd_valid), .o_fwd_addr(o_fwd_addr),
    .o_fwd_port(o_fwd_port));
  rta_bcc_sink u_sink (.i_clk(i_clk), .i_fwd_valid(o_fwd_valid),
    .i_fwd_addr(o_fwd_addr), .i_fwd_port(o_fwd_port));

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Each access ends with an idle edge so no strobe is lowered and raised at once
  task automatic wr(input logic p, input logic [7:0] a, input logic [7:0] d);
    i_port_sel  = p;
    i_reg_addr  = a;
    i_reg_wdata = d;
    i_reg_wr    = 1'b1;
    @(posedge i_clk);
    #1 i_reg_wr = 1'b0;
    if (a >= 8'h60 && a <= 8'h64) mdl[p][a-8'h60] = d[7:1];
    @(posedge i_clk);
    #1;
  endtask

  // Write and read in one cycle see the old byte; the read just after sees the new one
  task automatic wr_rd(input logic p, input logic [7:0] a, input logic [7:0] d);
    i_port_sel  = p;
    i_reg_addr  = a;
    i_reg_wdata = d;
    i_reg_wr    = 1'b1;
    i_reg_rd    = 1'b1;
    @(posedge i_clk);
    #1 i_reg_wr = 1'b0;
    chk(o_reg_rdata, {mdl[p][a-8'h60], 1'b0});
    mdl[p][a-8'h60] = d[7:1];
    @(posedge i_clk);
    #1 i_reg_rd = 1'b0;
    chk(o_reg_rdata, {mdl[p][a-8'h60], 1'b0});
    chk({7'h0, o_reg_hit}, 8'h01);
    @(posedge i_clk);
    #1;
  endtask

  task automatic rd(input logic p, input logic [7:0] a);
    logic hit;
    hit        = (a >= 8'h60 && a <= 8'h64);
    i_port_sel = p;
    i_reg_addr = a;
    i_reg_rd   = 1'b1;
    @(posedge i_clk);
    #1 i_reg_rd = 1'b0;
    chk(o_reg_rdata, hit ? {mdl[p][a-8'h60], 1'b0} : 8'h00);
    chk({7'h0, o_reg_hit}, {7'h0, hit});
    @(posedge i_clk);
    #1;
  endtask

  task automatic xl(input logic p, input logic [2:0] s, input logic [6:0] al);
    logic go;
    go           = (s >= 3'h3) && (al != 7'h00);
    i_xlat_port  = p;
    i_xlat_slot  = s;
    i_xlat_alias = al;
    i_xlat_req   = 1'b1;
    @(posedge i_clk);
    #1 i_xlat_req = 1'b0;
    chk({7'h0, o_fwd_valid}, {7'h0, go});
    if (go) nfwd++;
    if (go) lastf = {mdl[p][s-3'h3], p};
    chk({o_fwd_addr, o_fwd_port}, lastf);
    @(posedge i_clk);
    #1;
  endtask

  task automatic rd_all();
    for (int a = 'h60; a <= 'h64; a++)
    begin
      rd(1'b0, a[7:0]);
      rd(1'b1, a[7:0]);
    end
  endtask

  task automatic do_rst();
    i_rst = 1'b1;
    foreach (mdl[p, s]) mdl[p][s] = 7'h00;
    lastf = 8'h00;
    repeat (10) @(posedge i_clk);
    #1 i_rst = 1'b0;
  endtask

  task automatic summarize();
    $display("Checks %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    logic [31:0] r;
    logic [7:0]  uc [4];
    do_rst();
    rd_all();
    $display("Test reset values done");
    for (int a = 'h60; a <= 'h64; a++)
    begin
      r = rnd();
      wr(1'b0, a[7:0], r[7:0]);
      wr(1'b1, a[7:0], r[15:8]);
    end
    rd_all();
    $display("Test per-port storage done");
    uc = '{8'h5d, 8'h5e, 8'h5f, 8'h65};
    foreach (uc[i])
    begin
      r = rnd();
      wr(r[8], uc[i], r[7:0]);
      rd(r[8], uc[i]);
    end
    rd_all();
    $display("Test unclaimed addresses done");
    for (int a = 'h60; a <= 'h64; a++)
    begin
      r = rnd();
      wr_rd(r[8], a[7:0], r[7:0]);
    end
    rd_all();
    $display("Test write then read done");
    for (int s = 0; s < 8; s++)
    begin
      r = rnd();
      xl(r[9], s[2:0], r[6:0] | 7'h01);
      xl(~r[9], s[2:0], r[6:0] | 7'h01);
      xl(r[9], s[2:0], 7'h00);
    end
    chk(8'(u_sink.got_q.size()), 8'(nfwd));
    $display("Test remap done");
    do_rst();
    chk({o_fwd_addr, o_fwd_port}, 8'h00);
    rd_all();
    $display("Test mid-run reset done");
    summarize();
  end

  initial
  begin
    #20000;
    fails++;
    summarize();
  end
endmodule

// *** rtl/rta_pkg.sv ***
// Constants shared by the remote target address remap block
package rta_pkg;
  localparam int unsigned ADDR_W        = 8;
  localparam int unsigned DATA_W        = 8;
  localparam int unsigned PHYS_W        = 7;
  localparam int unsigned SLOT_W        = 3;
  localparam int unsigned NUM_SLOTS     = 5;
  localparam int unsigned NUM_PORTS_DEF = 2;
  // Register offsets of the target slots held here
  localparam logic [7:0] REMOTE_TARGET_ADDR_3 = 8'h60;
  localparam logic [7:0] REMOTE_TARGET_ADDR_4 = 8'h61;
  localparam logic [7:0] REMOTE_TARGET_ADDR_5 = 8'h62;
  localparam logic [7:0] REMOTE_TARGET_ADDR_6 = 8'h63;
  localparam logic [7:0] REMOTE_TARGET_ADDR_7 = 8'h64;
  // Slots 0 to 2 live elsewhere in the unit, just below slot 3
  localparam logic [7:0] REMOTE_TARGET_ADDR_0 = 8'h5d;
  localparam logic [7:0] REMOTE_TARGET_ADDR_2 = 8'h5f;
  // Lowest slot index held by this block
  localparam logic [2:0] FIRST_SLOT     = 3'h3;
  localparam logic [2:0] LAST_SLOT      = 3'h7;
  // Field layout and reset values
  localparam int unsigned PHYS_MSB      = 7;
  localparam int unsigned PHYS_LSB      = 1;
  localparam logic [6:0]  PHYS_RESET    = 7'h00;
  localparam logic [6:0]  ALIAS_OFF     = 7'h00;
  localparam logic        RSVD_BIT_VAL  = 1'b0;
  localparam logic [7:0]  RDATA_RESET   = 8'h00;
endpackage

// *** rtl/rta_remap.sv ***
// Per-port remote target physical address slots 3 to 7 and alias remap
`timescale 1ns/1ps

//////////////////////////////////////////////////////////////////////////////
module rta_remap #(
  parameter int unsigned NUM_PORTS = rta_pkg::NUM_PORTS_DEF
) (
  input  wire logic                          i_clk,
  input  wire logic                          i_rst,
  input  wire logic [$clog2(NUM_PORTS)-1:0]  i_port_sel,
  input  wire logic                          i_reg_wr,
  input  wire logic                          i_reg_rd,
  input  wire logic [rta_pkg::ADDR_W-1:0]    i_reg_addr,
  input  wire logic [rta_pkg::DATA_W-1:0]    i_reg_wdata,
  output logic      [rta_pkg::DATA_W-1:0]    o_reg_rdata,
  output logic                               o_reg_hit,
  input  wire logic                          i_xlat_req,
  input  wire logic [$clog2(NUM_PORTS)-1:0]  i_xlat_port,
  input  wire logic [rta_pkg::SLOT_W-1:0]    i_xlat_slot,
  input  wire logic [rta_pkg::PHYS_W-1:0]    i_xlat_alias,
  output logic                               o_fwd_valid,
  output logic      [rta_pkg::PHYS_W-1:0]    o_fwd_addr,
  output logic      [$clog2(NUM_PORTS)-1:0]  o_fwd_port
);
  import rta_pkg::*;

  localparam int unsigned PW = $clog2(NUM_PORTS);

  if (NUM_PORTS < 2 || NUM_PORTS > 8)
  begin : g_chk
    $error("rta_remap: NUM_PORTS must be 2 to 8");
  end

  //////////////////////////////////////////////////////////////////////////////
  // Address decode

  logic            acc_hit;
  logic [2:0]      acc_idx;
  logic [ADDR_W:0] acc_off;

  always_comb
  begin
    acc_off = {1'b0, i_reg_addr} - {1'b0, REMOTE_TARGET_ADDR_3};
    // Only 0x60..0x64 belong here; 0x5D..0x5F fall below and miss
    acc_hit = (i_reg_addr >= REMOTE_TARGET_ADDR_3) && (i_reg_addr <= REMOTE_TARGET_ADDR_7);
    acc_idx = acc_off[2:0];
  end

  //////////////////////////////////////////////////////////////////////////////
  // Slot storage, one bank per receive port

  logic [PHYS_W-1:0] tgt_q [NUM_PORTS][NUM_SLOTS];
  logic [PHYS_W-1:0] tgt_d [NUM_PORTS][NUM_SLOTS];

  always_comb
  begin
    tgt_d = tgt_q;
    // Only the selected port's copy takes the write
    if (i_reg_wr && acc_hit)
    begin
      // Bit 0 is never stored, so it cannot be written
      tgt_d[i_port_sel][acc_idx] = i_reg_wdata[PHYS_MSB:PHYS_LSB];
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      for (int p = 0; p < NUM_PORTS; p++)
      begin
        for (int s = 0; s < NUM_SLOTS; s++)
        begin
          tgt_q[p][s] <= PHYS_RESET;
        end
      end
    end
    else
    begin
      tgt_q <= tgt_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read path, one cycle latency so the outputs come from flops

  logic [DATA_W-1:0] rdata_d;
  logic              hit_d;

  always_comb
  begin
    rdata_d = o_reg_rdata;
    hit_d   = 1'b0;
    if (i_reg_rd)
    begin
      hit_d   = acc_hit;
      // Unclaimed addresses return zero so the owner of them can OR buses
      rdata_d = acc_hit ? {tgt_q[i_port_sel][acc_idx], RSVD_BIT_VAL}
                        : RDATA_RESET;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_reg_rdata <= RDATA_RESET;
      o_reg_hit   <= 1'b0;
    end
    else
    begin
      o_reg_rdata <= rdata_d;
      o_reg_hit   <= hit_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Alias remap toward the back control channel

  logic              slot_ok;
  logic [2:0]        xl_idx;
  logic [PHYS_W-1:0] xl_tgt;
  logic              fwd_valid_d;
  logic [PHYS_W-1:0] fwd_addr_d;
  logic [PW-1:0]     fwd_port_d;

  always_comb
  begin
    slot_ok     = (i_xlat_slot >= FIRST_SLOT);
    // Slots below three look up entry zero of the bank, so the lookup stays in range
    xl_idx      = slot_ok ? 3'(i_xlat_slot - FIRST_SLOT) : '0;
    xl_tgt      = tgt_q[i_xlat_port][xl_idx];
    fwd_valid_d = 1'b0;
    fwd_addr_d  = o_fwd_addr;
    fwd_port_d  = o_fwd_port;
    // A zero alias never matches, so nothing is forwarded
    if (i_xlat_req && slot_ok && (i_xlat_alias != ALIAS_OFF))
    begin
      fwd_valid_d = 1'b1;
      fwd_addr_d  = xl_tgt;
      fwd_port_d  = i_xlat_port;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_fwd_valid <= 1'b0;
      o_fwd_addr  <= PHYS_RESET;
      o_fwd_port  <= '0;
    end
    else
    begin
      o_fwd_valid <= fwd_valid_d;
      o_fwd_addr  <= fwd_addr_d;
      o_fwd_port  <= fwd_port_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Assertions

  logic other_chg;

  always_comb
  begin
    other_chg = 1'b0;
    for (int p = 0; p < NUM_PORTS; p++)
    begin
      for (int s = 0; s < NUM_SLOTS; s++)
      begin
        if ((p[PW-1:0] != i_port_sel) && (tgt_d[p][s] != tgt_q[p][s]))
        begin
          other_chg = 1'b1;
        end
      end
    end
  end

  sequence s_wr_hit;
    i_reg_wr && acc_hit;
  endsequence

  sequence s_rd_same;
    i_reg_rd && !i_reg_wr && (i_reg_addr == $past(i_reg_addr))
      && (i_port_sel == $past(i_port_sel));
  endsequence

  AST_OTHER_PORT_UNTOUCHED: assert property (@(posedge i_clk) disable iff (i_rst)
    !other_chg)
    else $error("write reached a port copy that was not selected");

  AST_WRITE_READ_BACK: assert property (@(posedge i_clk) disable iff (i_rst)
    s_wr_hit ##1 s_rd_same |=> o_reg_hit && !o_reg_rdata[0]
      && (o_reg_rdata[PHYS_MSB:PHYS_LSB] == $past(i_reg_wdata[PHYS_MSB:PHYS_LSB], 2)))
    else $error("read did not return the value written");

  AST_HIT_RANGE: assert property (@(posedge i_clk) disable iff (i_rst)
    i_reg_rd |=> o_reg_hit == (($past(i_reg_addr) >= REMOTE_TARGET_ADDR_3)
      && ($past(i_reg_addr) <= REMOTE_TARGET_ADDR_7)))
    else $error("hit flag disagrees with the slot address range");

  AST_LOW_SLOTS_MISS: assert property (@(posedge i_clk) disable iff (i_rst)
    i_reg_rd && (i_reg_addr >= REMOTE_TARGET_ADDR_0) && (i_reg_addr <= REMOTE_TARGET_ADDR_2)
      |=> !o_reg_hit && (o_reg_rdata == RDATA_RESET))
    else $error("slots zero to two were claimed");

  AST_BIT0_ZERO: assert property (@(posedge i_clk) disable iff (i_rst)
    o_reg_hit |-> !o_reg_rdata[0])
    else $error("reserved bit read as one");

  AST_REMAP_ADDR: assert property (@(posedge i_clk) disable iff (i_rst)
    i_xlat_req && slot_ok && (i_xlat_alias != ALIAS_OFF)
      |=> o_fwd_valid && (o_fwd_addr == $past(xl_tgt)) && (o_fwd_port == $past(i_xlat_port)))
    else $error("forwarded address is not the stored physical address");

  AST_ALIAS_ZERO_BLOCK: assert property (@(posedge i_clk) disable iff (i_rst)
    i_xlat_req && (i_xlat_alias == ALIAS_OFF) |=> !o_fwd_valid)
    else $error("slot with zero alias was forwarded");

  AST_RESET_CLEAR: assert property (@(posedge i_clk)
    $past(i_rst) && !i_rst |-> !o_fwd_valid && !o_reg_hit && (o_reg_rdata == RDATA_RESET)
      && (tgt_q[0][0] == PHYS_RESET))
    else $error("state not zero after reset");

  AST_FWD_ONE_CYCLE: assert property (@(posedge i_clk) disable iff (i_rst)
    o_fwd_valid |-> $past(i_xlat_req))
    else $error("forward pulse without a request");
endmodule
